// ==== inc/fsg_pkg.sv ====
// Behaviour
// - Frame sync drives only when enabled
// - Multiframe sync drives only when enabled
// - Disabled sync output held low
// - Frame clock mode: 8kHz, equal halves
// - Frame pulse mode: one third-clock period low
// - Frame invert flips clock or pulse
// - Multiframe clock mode: 2kHz, equal halves
// - Multiframe pulse mode: one third-clock period low
// - Multiframe invert flips clock or pulse
// - Direct-locked, no build-out: ref-rate output aligned
// - Faster outputs fall with ref-rate output
package fsg_pkg;
    // Register byte offsets
    localparam logic [3:0] FSG_OFS_OUT_CFG  = 4'h0;
    localparam logic [3:0] FSG_OFS_SYNC_CFG = 4'h4;
    localparam logic [3:0] FSG_OFS_PBO_CFG  = 4'h8;
    localparam logic [3:0] FSG_OFS_STATUS   = 4'hC;
    // Field positions
    localparam int FSG_BIT_FRAME_EN     = 0;
    localparam int FSG_BIT_MF_EN        = 1;
    localparam int FSG_BIT_FRAME_PULSE  = 0;
    localparam int FSG_BIT_FRAME_INV    = 1;
    localparam int FSG_BIT_MF_PULSE     = 2;
    localparam int FSG_BIT_MF_INV       = 3;
    localparam int FSG_BIT_MAIN_PBO     = 0;
    localparam int FSG_BIT_SEC_PBO      = 1;
    // Reset values
    localparam logic [1:0] FSG_RST_OUT_CFG  = 2'h0;
    localparam logic [3:0] FSG_RST_SYNC_CFG = 4'h0;
    localparam logic [1:0] FSG_RST_PBO_CFG  = 2'h3;
    // Timing
    localparam int FSG_CLK_PERIOD_NS   = 25;
    localparam int FSG_FRAME_PERIOD_NS = 125000;
    localparam int FSG_MF_PERIOD_NS    = 500000;
    localparam int FSG_FRAME_CYCLES    = FSG_FRAME_PERIOD_NS / FSG_CLK_PERIOD_NS;
    localparam int FSG_FRAMES_PER_MF   = FSG_MF_PERIOD_NS / FSG_FRAME_PERIOD_NS;
    localparam int FSG_REF_HALF_CYCLES = 4;
    localparam int FSG_FAST_DIV        = 2;
endpackage

// ==== hw/fsg_edge_divider.sv ====
`timescale 1ns/1ps
// Derives a reference-rate clock and a faster clock from one DPLL path
module fsg_edge_divider #(
    parameter int REF_HALF = fsg_pkg::FSG_REF_HALF_CYCLES,
    parameter int FAST_DIV = fsg_pkg::FSG_FAST_DIV
) (
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    input  wire logic ref_level_in,
    input  wire logic align_in,
    output logic      ref_rate_clk_out,
    output logic      fast_clk_out
);
    localparam int FAST_HALF = REF_HALF / FAST_DIV;

    typedef struct packed {
        logic       ref_prev;
        logic [7:0] ref_cnt;
        logic [7:0] fast_cnt;
        logic       ref_clk;
        logic       fast_clk;
    } fsg_div_state_t;

    fsg_div_state_t s_q;
    fsg_div_state_t s_d;

    // Free-run dividers, pulled onto the reference edges when aligned
    always_comb begin
        s_d          = s_q;
        s_d.ref_prev = ref_level_in;
        if (s_q.ref_cnt == 8'(REF_HALF - 1)) begin
            s_d.ref_cnt = 8'h00;
            s_d.ref_clk = ~s_q.ref_clk;
        end else begin
            s_d.ref_cnt = s_q.ref_cnt + 8'h01;
        end
        if (s_q.fast_cnt == 8'(FAST_HALF - 1)) begin
            s_d.fast_cnt = 8'h00;
            s_d.fast_clk = ~s_q.fast_clk;
        end else begin
            s_d.fast_cnt = s_q.fast_cnt + 8'h01;
        end
        if (align_in) begin
            s_d.ref_clk = ref_level_in;
            if (s_q.ref_prev && !ref_level_in) begin
                // Falling edges line up; counters restart from here
                s_d.ref_cnt  = 8'h00;
                s_d.fast_cnt = 8'h00;
                s_d.fast_clk = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ref_rate_clk_out = s_q.ref_clk;
    assign fast_clk_out     = s_q.fast_clk;
endmodule // fsg_edge_divider

// ==== hw/fsg_frame_sync_gen.sv ====
`timescale 1ns/1ps
// Frame and multiframe sync generator with derived-clock alignment
module fsg_frame_sync_gen #(
    parameter int FRAME_CYCLES = fsg_pkg::FSG_FRAME_CYCLES,
    parameter int REF_HALF     = fsg_pkg::FSG_REF_HALF_CYCLES
) (
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    // Wishbone classic slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [3:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic [31:0]      wb_dat_out,
    output logic             wb_ack_out,
    // Third output clock, arrives as a pin
    input  wire logic        third_output_clock_in,
    // Selected references of the two DPLL paths, pins
    input  wire logic        main_ref_clk_in,
    input  wire logic        sec_ref_clk_in,
    // Direct-lock status from the DPLLs, same clock
    input  wire logic        main_dpll_path_locked_in,
    input  wire logic        secondary_dpll_path_locked_in,
    // Sync outputs
    output logic             frame_sync_out,
    output logic             multiframe_sync_out,
    // Derived output clocks
    output logic             main_ref_rate_clk_out,
    output logic             main_fast_clk_out,
    output logic             sec_ref_rate_clk_out,
    output logic             sec_fast_clk_out
);
    localparam int FRAME_HALF = FRAME_CYCLES / 2;
    localparam int MF_HALF    = fsg_pkg::FSG_FRAMES_PER_MF / 2;

    typedef struct packed {
        // Synchronisers
        logic        third_s1;
        logic        third_s2;
        logic        third_s3;
        logic        main_s1;
        logic        main_s2;
        logic        sec_s1;
        logic        sec_s2;
        // Software controls
        logic        frame_out_enable;
        logic        multiframe_out_enable;
        logic        frame_pulse_select;
        logic        frame_invert;
        logic        multiframe_pulse_select;
        logic        multiframe_invert;
        logic        main_pbo_en;
        logic        sec_pbo_en;
        // Timing chain
        logic [15:0] base_cnt;
        logic [1:0]  frame_idx;
        logic        frame_arm;
        logic        frame_pulse;
        logic        mf_arm;
        logic        mf_pulse;
        // Outputs
        logic        frame_sync;
        logic        mf_sync;
        logic        ack;
        logic [31:0] rdata;
    } fsg_state_t;

    fsg_state_t s_q;
    fsg_state_t s_d;

    logic main_align;
    logic sec_align;

    // Shapes one sync output from its square, pulse and control bits
    function automatic logic fsg_shape(
        input logic en,
        input logic pulse_sel,
        input logic inv,
        input logic square,
        input logic pulse_active
    );
        logic raw;
        raw = pulse_sel ? ~pulse_active : square;
        return en ? (raw ^ inv) : 1'b0;
    endfunction

    // Alignment only when direct-locked with build-out off
    assign main_align = main_dpll_path_locked_in & ~s_q.main_pbo_en;
    assign sec_align  = secondary_dpll_path_locked_in & ~s_q.sec_pbo_en;

    always_comb begin
        logic        third_rise;
        logic        frame_wrap;
        logic        req;
        logic        frame_sq;
        logic        mf_sq;
        third_rise = 1'b0;
        frame_wrap = 1'b0;
        req        = 1'b0;
        frame_sq   = 1'b0;
        mf_sq      = 1'b0;
        s_d        = s_q;

        // Pin inputs pass two flops; the first is read by nothing else
        s_d.third_s1 = third_output_clock_in;
        s_d.third_s2 = s_q.third_s1;
        s_d.third_s3 = s_q.third_s2;
        s_d.main_s1  = main_ref_clk_in;
        s_d.main_s2  = s_q.main_s1;
        s_d.sec_s1   = sec_ref_clk_in;
        s_d.sec_s2   = s_q.sec_s1;
        third_rise   = s_q.third_s2 & ~s_q.third_s3;

        // One counter chain feeds both rates so frames nest in multiframes
        frame_wrap = (s_q.base_cnt == 16'(FRAME_CYCLES - 1));
        if (frame_wrap) begin
            s_d.base_cnt  = 16'h0000;
            s_d.frame_idx = s_q.frame_idx + 2'h1;
        end else begin
            s_d.base_cnt = s_q.base_cnt + 16'h0001;
        end

        // Square waves, high for the first half of each period
        frame_sq = (s_q.base_cnt < 16'(FRAME_HALF));
        mf_sq    = (s_q.frame_idx < 2'(MF_HALF));

        // Pulses start at the third-clock edge after the boundary and end
        // at the next one; a slow third clock stretches them
        if (third_rise && s_q.frame_pulse) begin
            s_d.frame_pulse = 1'b0;
        end
        if (third_rise && s_q.mf_pulse) begin
            s_d.mf_pulse = 1'b0;
        end
        if (third_rise && s_q.frame_arm) begin
            s_d.frame_arm   = 1'b0;
            s_d.frame_pulse = 1'b1;
        end
        if (third_rise && s_q.mf_arm) begin
            s_d.mf_arm   = 1'b0;
            s_d.mf_pulse = 1'b1;
        end
        if (frame_wrap) begin
            s_d.frame_arm = 1'b1;
            if (s_q.frame_idx == 2'h3) begin
                s_d.mf_arm = 1'b1;
            end
        end

        // Output shaping, registered so the pins never glitch
        s_d.frame_sync = fsg_shape(s_q.frame_out_enable,
                                   s_q.frame_pulse_select,
                                   s_q.frame_invert,
                                   frame_sq,
                                   s_q.frame_pulse);
        s_d.mf_sync = fsg_shape(s_q.multiframe_out_enable,
                                s_q.multiframe_pulse_select,
                                s_q.multiframe_invert,
                                mf_sq,
                                s_q.mf_pulse);

        // Wishbone: answer one cycle after the request, drop next cycle
        req    = wb_cyc_in & wb_stb_in & ~s_q.ack;
        s_d.ack = req;
        if (req && wb_we_in && wb_sel_in[0]) begin
            unique case (wb_adr_in)
                fsg_pkg::FSG_OFS_OUT_CFG: begin
                    s_d.frame_out_enable =
                        wb_dat_in[fsg_pkg::FSG_BIT_FRAME_EN];
                    s_d.multiframe_out_enable =
                        wb_dat_in[fsg_pkg::FSG_BIT_MF_EN];
                end
                fsg_pkg::FSG_OFS_SYNC_CFG: begin
                    s_d.frame_pulse_select =
                        wb_dat_in[fsg_pkg::FSG_BIT_FRAME_PULSE];
                    s_d.frame_invert =
                        wb_dat_in[fsg_pkg::FSG_BIT_FRAME_INV];
                    s_d.multiframe_pulse_select =
                        wb_dat_in[fsg_pkg::FSG_BIT_MF_PULSE];
                    s_d.multiframe_invert =
                        wb_dat_in[fsg_pkg::FSG_BIT_MF_INV];
                end
                fsg_pkg::FSG_OFS_PBO_CFG: begin
                    s_d.main_pbo_en = wb_dat_in[fsg_pkg::FSG_BIT_MAIN_PBO];
                    s_d.sec_pbo_en  = wb_dat_in[fsg_pkg::FSG_BIT_SEC_PBO];
                end
                default: begin
                end
            endcase
        end

        // Read data; unmapped offsets answer with zero
        s_d.rdata = 32'h0000_0000;
        if (req && !wb_we_in) begin
            unique case (wb_adr_in)
                fsg_pkg::FSG_OFS_OUT_CFG: begin
                    s_d.rdata[1:0] = {s_q.multiframe_out_enable,
                                      s_q.frame_out_enable};
                end
                fsg_pkg::FSG_OFS_SYNC_CFG: begin
                    s_d.rdata[3:0] = {s_q.multiframe_invert,
                                      s_q.multiframe_pulse_select,
                                      s_q.frame_invert,
                                      s_q.frame_pulse_select};
                end
                fsg_pkg::FSG_OFS_PBO_CFG: begin
                    s_d.rdata[1:0] = {s_q.sec_pbo_en, s_q.main_pbo_en};
                end
                fsg_pkg::FSG_OFS_STATUS: begin
                    s_d.rdata[7:0] = {s_q.frame_pulse,
                                      s_q.mf_pulse,
                                      s_q.frame_idx,
                                      sec_align,
                                      main_align,
                                      s_q.mf_sync,
                                      s_q.frame_sync};
                end
                default: begin
                end
            endcase
        end
    end

    // Single state register
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
            s_q.frame_out_enable      <= fsg_pkg::FSG_RST_OUT_CFG[0];
            s_q.multiframe_out_enable <= fsg_pkg::FSG_RST_OUT_CFG[1];
            s_q.frame_pulse_select    <= fsg_pkg::FSG_RST_SYNC_CFG[0];
            s_q.frame_invert          <= fsg_pkg::FSG_RST_SYNC_CFG[1];
            s_q.multiframe_pulse_select <= fsg_pkg::FSG_RST_SYNC_CFG[2];
            s_q.multiframe_invert     <= fsg_pkg::FSG_RST_SYNC_CFG[3];
            s_q.main_pbo_en           <= fsg_pkg::FSG_RST_PBO_CFG[0];
            s_q.sec_pbo_en            <= fsg_pkg::FSG_RST_PBO_CFG[1];
        end else begin
            s_q <= s_d;
        end
    end

    // Main path derived clocks
    fsg_edge_divider #(
        .REF_HALF (REF_HALF),
        .FAST_DIV (fsg_pkg::FSG_FAST_DIV)
    ) u_main_div (
        .core_clk_in      (core_clk_in),
        .rst_n_in         (rst_n_in),
        .ref_level_in     (s_q.main_s2),
        .align_in         (main_align),
        .ref_rate_clk_out (main_ref_rate_clk_out),
        .fast_clk_out     (main_fast_clk_out)
    );

    // Secondary path behaves the same way
    fsg_edge_divider #(
        .REF_HALF (REF_HALF),
        .FAST_DIV (fsg_pkg::FSG_FAST_DIV)
    ) u_sec_div (
        .core_clk_in      (core_clk_in),
        .rst_n_in         (rst_n_in),
        .ref_level_in     (s_q.sec_s2),
        .align_in         (sec_align),
        .ref_rate_clk_out (sec_ref_rate_clk_out),
        .fast_clk_out     (sec_fast_clk_out)
    );

    assign frame_sync_out      = s_q.frame_sync;
    assign multiframe_sync_out = s_q.mf_sync;
    assign wb_ack_out          = s_q.ack;
    assign wb_dat_out          = s_q.rdata;
endmodule // fsg_frame_sync_gen

// ==== bench/fsg_frame_sync_gen_sva.sv ====
`timescale 1ns/1ps
// Port checker; register shadows are rebuilt from bus writes
module fsg_frame_sync_gen_chk #(
    parameter int FRAME_CYCLES = fsg_pkg::FSG_FRAME_CYCLES
) (
    input wire logic        core_clk_in,
    input wire logic        rst_n_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_we_in,
    input wire logic [3:0]  wb_adr_in,
    input wire logic [3:0]  wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic        wb_ack_out,
    input wire logic        main_ref_clk_in,
    input wire logic        sec_ref_clk_in,
    input wire logic        main_dpll_path_locked_in,
    input wire logic        secondary_dpll_path_locked_in,
    input wire logic        frame_sync_out,
    input wire logic        multiframe_sync_out,
    input wire logic        main_ref_rate_clk_out,
    input wire logic        main_fast_clk_out,
    input wire logic        sec_ref_rate_clk_out,
    input wire logic        sec_fast_clk_out
);
    logic [1:0] en_q;
    logic [3:0] cfg_q;
    logic [1:0] pbo_q;
    int         age_q;
    int         run_q;
    logic       wr;
    logic       calm;
    // Shadows lag the design by a cycle; calm waits out the mode change
    assign wr   = wb_ack_out && wb_we_in && wb_sel_in[0];
    assign calm = age_q > 8 * FRAME_CYCLES;
    // Shadow registers, quiet-time counter and frame level run length
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            en_q  <= fsg_pkg::FSG_RST_OUT_CFG;
            cfg_q <= fsg_pkg::FSG_RST_SYNC_CFG;
            pbo_q <= fsg_pkg::FSG_RST_PBO_CFG;
            age_q <= 0;
            run_q <= 0;
        end else begin
            if (wr && wb_adr_in == fsg_pkg::FSG_OFS_OUT_CFG) en_q <= wb_dat_in[1:0];
            if (wr && wb_adr_in == fsg_pkg::FSG_OFS_SYNC_CFG) cfg_q <= wb_dat_in[3:0];
            if (wr && wb_adr_in == fsg_pkg::FSG_OFS_PBO_CFG) pbo_q <= wb_dat_in[1:0];
            age_q <= wr ? 0 : (calm ? age_q : age_q + 1);
            run_q <= $changed(frame_sync_out) ? 0 : run_q + 1;
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Pulse body for a third clock of four core cycles
    sequence s_frame_low;
        (!(frame_sync_out ^ cfg_q[1]))[*3] ##1 (frame_sync_out ^ cfg_q[1]);
    endsequence
    chk_frame_off: assert property (
        !en_q[0] && !$past(en_q[0]) |-> !frame_sync_out) else $error("frame sync on");
    chk_mf_off: assert property (
        !en_q[1] && !$past(en_q[1]) |-> !multiframe_sync_out) else $error("mf sync on");
    chk_ack_pulse: assert property (
        wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
        else $error("ack shape");
    chk_read_zero: assert property (
        !wb_ack_out || (!wb_we_in && wb_adr_in[1:0] != 2'h0) |-> wb_dat_out == 32'h0)
        else $error("read data not zero");
    chk_pulse_width: assert property (
        calm && en_q[0] && cfg_q[0] && $fell(frame_sync_out ^ cfg_q[1]) |=> s_frame_low)
        else $error("frame pulse width");
    chk_mf_on_frame: assert property (
        calm && en_q == 2'h3 && cfg_q[0] && cfg_q[2]
        && $fell(multiframe_sync_out ^ cfg_q[3]) |-> $fell(frame_sync_out ^ cfg_q[1]))
        else $error("mf pulse off frame");
    chk_frame_half: assert property (
        calm && en_q[0] && !cfg_q[0] && $changed(frame_sync_out)
        |-> run_q == FRAME_CYCLES / 2 - 1) else $error("frame half period");
    chk_main_align: assert property (
        calm && !pbo_q[0] && main_dpll_path_locked_in && $past(main_dpll_path_locked_in, 4)
        |-> main_ref_rate_clk_out == $past(main_ref_clk_in, 3)) else $error("main align");
    chk_fast_fall: assert property (
        calm && !pbo_q[0] && main_dpll_path_locked_in && $fell(main_ref_rate_clk_out)
        |-> !main_fast_clk_out) else $error("fast clock edge");
    chk_sec_align: assert property (
        calm && !pbo_q[1] && secondary_dpll_path_locked_in
        && $past(secondary_dpll_path_locked_in, 4)
        |-> sec_ref_rate_clk_out == $past(sec_ref_clk_in, 3)) else $error("sec align");
    chk_sec_fast_fall: assert property (
        calm && !pbo_q[1] && secondary_dpll_path_locked_in && $fell(sec_ref_rate_clk_out)
        |-> !sec_fast_clk_out) else $error("sec fast clock edge");
    // Square mode: every multiframe edge sits on a true frame rise, so a lost
    // frame invert in clock mode shows up here as a falling edge
    chk_square_nest: assert property (
        calm && en_q == 2'h3 && !cfg_q[0] && !cfg_q[2] && $changed(multiframe_sync_out)
        |-> $rose(frame_sync_out ^ cfg_q[1])) else $error("mf edge off frame rise");
endmodule // fsg_frame_sync_gen_chk

// ==== bench/fsg_sync_partner.sv ====
`timescale 1ns/1ps
// Far-side timing source: third output clock and both references
module fsg_sync_partner (
    input  wire logic core_clk_in,
    output logic      third_clk_out = 1'b0,
    output logic      main_ref_out = 1'b0,
    output logic      sec_ref_out = 1'b0
);
    logic [3:0] div_q = 4'h0;
    // A 10 MHz third clock stays clear of the minimum rate pulse modes need
    always @(posedge core_clk_in) begin
        div_q         <= div_q + 4'h1;
        third_clk_out <= div_q[1];
        main_ref_out  <= div_q[2];
        sec_ref_out   <= div_q[3];
    end
endmodule // fsg_sync_partner

// ==== bench/fsg_frame_sync_gen_bench.sv ====
`timescale 1ns/1ps
// Bench: Wishbone register tasks and sync level run measurements
module fsg_frame_sync_gen_bench;
    localparam int F  = 40;
    localparam int TP = 4;
    logic        core_clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        wb_cyc_in = 1'b0;
    logic        wb_stb_in = 1'b0;
    logic        wb_we_in = 1'b0;
    logic [3:0]  wb_adr_in = 4'h0;
    logic [3:0]  wb_sel_in = 4'h0;
    logic [31:0] wb_dat_in = 32'h0;
    logic [31:0] wb_dat_out;
    logic        wb_ack_out;
    logic        third_output_clock_in;
    logic        main_ref_clk_in;
    logic        sec_ref_clk_in;
    logic        main_dpll_path_locked_in = 1'b0;
    logic        secondary_dpll_path_locked_in = 1'b0;
    logic        frame_sync_out;
    logic        multiframe_sync_out;
    logic        main_ref_rate_clk_out;
    logic        main_fast_clk_out;
    logic        sec_ref_rate_clk_out;
    logic        sec_fast_clk_out;
    logic [1:0]  syncs;
    logic [31:0] q;
    int          n_mismatch = 0;
    int          checks = 0;
    int          n;
    int          ex [5];
    // Rows: sync config, output, level, expected run kind
    logic [15:0] rows [13] = '{16'h0010, 16'h0000, 16'h0111, 16'h0101, 16'h5002, 16'h5013,
                               16'h5102, 16'h5114, 16'hF012, 16'hF003, 16'hF112, 16'hA010,
                               16'hA111};
    assign syncs = {multiframe_sync_out, frame_sync_out};
    fsg_frame_sync_gen #(.FRAME_CYCLES(F)) u_dut (.*);
    fsg_sync_partner u_far (
        .core_clk_in  (core_clk_in),
        .third_clk_out(third_output_clock_in),
        .main_ref_out (main_ref_clk_in),
        .sec_ref_out  (sec_ref_clk_in)
    );
    // 40 MHz clock
    always #12.5 core_clk_in = ~core_clk_in;
    // One classic cycle; request held until ack is sampled
    task automatic xfer(input logic [3:0] a, input logic w, input logic [3:0] s,
                        input logic [31:0] d);
        int t;
        t = 0;
        @(posedge core_clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in  <= w;
        wb_adr_in <= a;
        wb_sel_in <= s;
        wb_dat_in <= d;
        do begin
            @(posedge core_clk_in);
            t++;
        end while (wb_ack_out !== 1'b1 && t < 20);
        q = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        if (t >= 20) n_mismatch++;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Length of the next whole run at level lv
    task automatic span(input logic w, input logic lv, output int len);
        int t;
        t = 0;
        len = 0;
        while (syncs[w] === lv && t < 1000) begin
            @(posedge core_clk_in);
            t++;
        end
        while (syncs[w] !== lv && t < 2000) begin
            @(posedge core_clk_in);
            t++;
        end
        while (syncs[w] === lv && len < 1000) begin
            @(posedge core_clk_in);
            len++;
        end
    endtask
    // Cycles at anything but low, over more than a multiframe
    task automatic quiet(input logic w, output int hits);
        hits = 0;
        @(posedge core_clk_in);
        repeat (5 * F) begin
            @(posedge core_clk_in);
            if (syncs[w] !== 1'b0) hits++;
        end
    endtask
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        ex = '{F / 2, 2 * F, TP, F - TP, 4 * F - TP};
        repeat (10) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        xfer(4'h8, 1'b0, 4'hF, 32'h0);
        check("pbo reset", q, 32'(fsg_pkg::FSG_RST_PBO_CFG));
        xfer(4'h0, 1'b1, 4'hE, 32'h3);
        xfer(4'h0, 1'b0, 4'hF, 32'h0);
        check("out cfg", q, 32'h0);
        xfer(4'h6, 1'b0, 4'hF, 32'h0);
        check("unmapped", q, 32'h0);
        xfer(4'h4, 1'b1, 4'hF, 32'hF);
        quiet(1'b0, n);
        check("frame idle", n, 0);
        quiet(1'b1, n);
        check("mf idle", n, 0);
        $display("Test registers done");
        xfer(4'h0, 1'b1, 4'hF, 32'h3);
        foreach (rows[i]) begin
            if (i == 0 || rows[i][15:12] != rows[i-1][15:12])
                xfer(4'h4, 1'b1, 4'hF, {28'h0, rows[i][15:12]});
            span(rows[i][8], rows[i][4], n);
            span(rows[i][8], rows[i][4], n);
            check("sync run", n, ex[rows[i][3:0]]);
        end
        $display("Test sync shapes done");
        xfer(4'h4, 1'b1, 4'hF, 32'hF);
        for (int e = 1; e < 3; e++) begin
            xfer(4'h0, 1'b1, 4'hF, 32'(e));
            quiet(e == 1, n);
            check("disabled low", n, 0);
            span(e == 2, 1'b1, n);
            check("enabled pulse", n, TP);
        end
        $display("Test enables done");
        main_dpll_path_locked_in <= 1'b1;
        xfer(4'h8, 1'b1, 4'hF, 32'h0);
        repeat (10 * F) @(posedge core_clk_in);
        xfer(4'hC, 1'b0, 4'hF, 32'h0);
        check("main aligned", {30'h0, q[3:2]}, 32'h1);
        secondary_dpll_path_locked_in <= 1'b1;
        repeat (10 * F) @(posedge core_clk_in);
        xfer(4'hC, 1'b0, 4'hF, 32'h0);
        check("both aligned", {30'h0, q[3:2]}, 32'h3);
        $display("Test clock alignment done");
        report_and_stop();
    end
    // Watchdog against a hung bus or a missing edge
    initial begin
        repeat (50000) @(posedge core_clk_in);
        n_mismatch++;
        report_and_stop();
    end
endmodule // fsg_frame_sync_gen_bench

bind fsg_frame_sync_gen fsg_frame_sync_gen_chk #(.FRAME_CYCLES(FRAME_CYCLES)) u_chk (.*);
